// [pwm_core_pkg.sv]
package pwm_core_pkg;

  // Counter geometry and fixed values
  localparam int unsigned CNT_W = 16;
  localparam int unsigned NUM_OUT = 2;
  localparam logic [15:0] CNT_INIT = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  // Port 20 direction register
  localparam logic [7:0] PORT20_DIR_RESET = 8'hFF;
  localparam int unsigned PORT20_FIXED_BIT = 7;

  // External interrupt routing choices
  localparam logic ROUTE_EXT_IRQ = 1'b0;
  localparam logic ROUTE_TIMER = 1'b1;

  // Input synchroniser depth
  localparam int unsigned SYNC_STAGES = 3;

  // Compare settings written by software
  typedef struct packed {
    logic [15:0] period;
    logic [1:0][15:0] set_cmp;
    logic [1:0][15:0] reset_cmp;
  } cmp_cfg_t;

  // Per-output control bits
  typedef struct packed {
    logic [1:0] output_enable_bit;
    logic [1:0] default_level_bit;
    logic [1:0] active_level_bit;
  } out_cfg_t;

  // Whole state of the core
  typedef struct packed {
    logic run;
    logic start_pend;
    logic en_prev;
    logic [15:0] cnt;
    cmp_cfg_t buf_cmp;
    logic load_pend;
    logic [1:0] oe_prev;
    logic [1:0] tod;
    logic [1:0] wave;
    logic [1:0] follow;
    logic [1:0] pin;
    logic [1:0] drive;
    logic irq;
    logic [1:0] ext_irq;
    logic [7:0] pm;
    logic [1:0][2:0] sync;
    logic [1:0] lvl;
    logic trig_pend;
  } core_state_t;

endpackage

// [pwm_timer_counter_output_core.sv]
`timescale 1ns/10ps
module pwm_timer_counter_output_core (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic count_tick,
  input wire logic counter_enable_bit,
  input wire logic period_by_trigger,
  input wire logic trig_load_en,
  input wire logic batch_load_req,
  input wire pwm_core_pkg::cmp_cfg_t cmp_cfg,
  input wire pwm_core_pkg::out_cfg_t out_cfg,
  input wire logic irq20_route_select,
  input wire logic irq21_route_select,
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  input wire logic port20_wr,
  input wire logic [7:0] port20_wdata,
  output logic [15:0] timer_up_counter,
  output logic timer_period_interrupt,
  output logic [1:0] pwm_output_pin,
  output logic [1:0] pwm_pin_drive,
  output logic [1:0] stop_release_irq,
  output logic [7:0] port20_direction
);

  // Pin level from tracking state, polarity and default level
  function automatic logic pin_level(input logic follow, input logic wave,
                                     input logic tol, input logic tod);
    if (follow) begin
      pin_level = wave ? ~tol : tol;
    end else begin
      pin_level = tod;
    end
  endfunction

  pwm_core_pkg::core_state_t q;
  pwm_core_pkg::core_state_t d;
  logic [1:0] pin_rise;
  logic [1:0] route;
  logic restart_trig;
  logic force_stop;
  logic trig_eff;
  logic period_match;
  logic load_now;

  // Filtered rising edges of the external pins
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_rise[i] = (q.sync[i][1] == q.sync[i][2]) && q.sync[i][2] &&
                    !q.lvl[i];
    end
  end

  // Pin routing to timer trigger or stop-release interrupt
  assign route = {irq21_route_select, irq20_route_select};
  assign restart_trig = pin_rise[1] && (route[1] == pwm_core_pkg::ROUTE_TIMER);
  assign force_stop = pin_rise[0] && (route[0] == pwm_core_pkg::ROUTE_TIMER);
  // A trigger edge counts at the tick that takes it, even if it came earlier
  assign trig_eff = period_by_trigger && (restart_trig || q.trig_pend);
  assign period_match = q.run && (q.cnt == q.buf_cmp.period);

  // Buffer load points: start, or clear with a pending request, or trigger clear with trig_load_en set
  assign load_now = count_tick && counter_enable_bit &&
                    (q.start_pend ||
                     (q.run && (period_match || trig_eff) &&
                      (q.load_pend || (trig_eff && trig_load_en))));

  // Next state
  always_comb begin
    logic [15:0] nxt;
    logic set_hit;
    logic rst_hit;
    pwm_core_pkg::cmp_cfg_t nb;
    nxt = q.cnt;
    set_hit = 1'b0;
    rst_hit = 1'b0;
    nb = q.buf_cmp;
    d = q;
    d.irq = 1'b0;
    d.ext_irq = 2'b00;

    // Three-stage synchronisers, level taken when stages two and three agree
    for (int i = 0; i < 2; i++) begin
      d.sync[i] = {q.sync[i][1], q.sync[i][0],
                   (i == 0) ? ext_irq_pin_a : ext_irq_pin_b};
      if (q.sync[i][1] == q.sync[i][2]) begin
        d.lvl[i] = q.sync[i][2];
      end
      if (pin_rise[i] && (route[i] == pwm_core_pkg::ROUTE_EXT_IRQ)) begin
        d.ext_irq[i] = 1'b1;
      end
    end

    // Hold a trigger edge until the next count tick takes it
    if (restart_trig && period_by_trigger) begin
      d.trig_pend = 1'b1;
    end
    if (count_tick) begin
      d.trig_pend = 1'b0;
    end

    // Sampled controls and port direction register
    d.en_prev = counter_enable_bit;
    d.oe_prev = out_cfg.output_enable_bit;
    d.tod = out_cfg.default_level_bit;
    d.drive = ~q.pm[1:0];
    if (port20_wr) begin
      d.pm = port20_wdata;
    end

    // Start request on enable rise, dropped if enable falls again
    if (counter_enable_bit && !q.en_prev && !q.run) begin
      d.start_pend = 1'b1;
    end
    if (!counter_enable_bit) begin
      d.start_pend = 1'b0;
    end

    if (load_now) begin
      nb = cmp_cfg;
      d.buf_cmp = cmp_cfg;
      d.load_pend = 1'b0;
    end
    // A new request in the load cycle survives the clear
    if (batch_load_req) begin
      d.load_pend = 1'b1;
    end

    if (count_tick) begin
      if (q.start_pend && counter_enable_bit) begin
        // First tick after enable: FFFFH wraps to 0000H
        nxt = q.cnt + pwm_core_pkg::CNT_ONE;
        d.cnt = nxt;
        d.run = 1'b1;
        d.start_pend = 1'b0;
        d.irq = 1'b1;
      end else if (q.run) begin
        if (period_match || trig_eff) begin
          nxt = pwm_core_pkg::CNT_ZERO;
        end else begin
          nxt = q.cnt + pwm_core_pkg::CNT_ONE;
        end
        d.cnt = nxt;
        if (period_match) begin
          d.irq = 1'b1;
        end
      end

      // Per-output waveform tracking on this tick
      for (int i = 0; i < 2; i++) begin
        if (q.run || q.start_pend) begin
          set_hit = (nxt == nb.set_cmp[i]);
          rst_hit = (nxt == nb.reset_cmp[i]);
          if (set_hit || rst_hit) begin
            d.wave[i] = set_hit && !rst_hit;
          end
        end else begin
          set_hit = 1'b0;
          rst_hit = 1'b0;
        end
        if (!q.oe_prev[i]) begin
          d.follow[i] = 1'b0;
        end else if (set_hit || rst_hit) begin
          d.follow[i] = 1'b1;
        end
        d.pin[i] = pin_level(d.follow[i], d.wave[i],
                             out_cfg.active_level_bit[i], q.tod[i]);
      end

      // Enable fell: stop after this tick's match effects
      if (q.run && !counter_enable_bit) begin
        d.cnt = pwm_core_pkg::CNT_INIT;
        d.run = 1'b0;
        d.wave = 2'b00;
        d.follow = 2'b00;
        d.pin = q.tod;
      end
    end

    // Forced output stop from the routed pin
    if (force_stop) begin
      d.follow = 2'b00;
      d.pin = q.tod;
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= '0;
      q.cnt <= pwm_core_pkg::CNT_INIT;
      q.pm <= pwm_core_pkg::PORT20_DIR_RESET;
      q.drive <= 2'b00;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign timer_up_counter = q.cnt;
  assign timer_period_interrupt = q.irq;
  assign pwm_output_pin = q.pin;
  assign pwm_pin_drive = q.drive;
  assign stop_release_irq = q.ext_irq;
  assign port20_direction = q.pm;

  // Checks
  sequence s_start_tick;
    clk_en && count_tick && q.start_pend && counter_enable_bit;
  endsequence

  sequence s_run_tick;
    clk_en && count_tick && q.run && counter_enable_bit;
  endsequence

  sequence s_force_cycle;
    clk_en && force_stop;
  endsequence

  sequence s_quiet_cycle;
    clk_en && !count_tick && !force_stop;
  endsequence

  // Counter held at its start value while stopped
  a_idle_holds_max: assert property (
    @(posedge core_clk) disable iff (rst)
    !q.run |-> q.cnt == 16'hFFFF)
    else $error("counter not at FFFFH while stopped");

  // First tick after enable wraps to zero with interrupt
  a_start_wraps_irq: assert property (
    @(posedge core_clk) disable iff (rst)
    s_start_tick |=> (q.cnt == 16'h0000) && q.irq && q.run)
    else $error("start did not wrap to zero with interrupt");

  // Enable rise is registered as a start request
  a_start_latency: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && counter_enable_bit && !q.en_prev && !q.run |=>
    q.start_pend || !counter_enable_bit)
    else $error("enable rise not registered as start");

  // Period match clears with interrupt
  a_match_clears: assert property (
    @(posedge core_clk) disable iff (rst)
    s_run_tick ##0 (q.cnt == q.buf_cmp.period) |=>
    (q.cnt == 16'h0000) && q.irq)
    else $error("period match did not clear with interrupt");

  // Trigger clear gives no interrupt
  a_trigger_no_irq: assert property (
    @(posedge core_clk) disable iff (rst)
    s_run_tick ##0 (trig_eff && !period_match) |=>
    (q.cnt == 16'h0000) && !q.irq)
    else $error("trigger clear wrong or raised interrupt");

  // Plain tick steps by one
  a_count_steps: assert property (
    @(posedge core_clk) disable iff (rst)
    s_run_tick ##0 (!period_match && !trig_eff) |=>
    q.cnt == $past(q.cnt) + 16'h0001)
    else $error("counter did not step by one");

  // Stop forces start value and default levels
  a_stop_defaults: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && count_tick && q.run && !counter_enable_bit |=>
    (q.cnt == 16'hFFFF) && !q.run && (q.pin == $past(q.tod)))
    else $error("stop did not force FFFFH and default levels");

  // Disabled output shows default level after a tick
  a_off_default: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && count_tick && !q.oe_prev[0] && !force_stop |=>
    pwm_output_pin[0] == $past(q.tod[0]))
    else $error("disabled output not at default level");

  // Match in the tick cycle still sets the output
  a_late_disable_set: assert property (
    @(posedge core_clk) disable iff (rst)
    s_run_tick ##0 (q.oe_prev[1] && !force_stop &&
    (d.cnt == q.buf_cmp.set_cmp[1]) && (d.cnt != q.buf_cmp.reset_cmp[1]) &&
    !load_now) |=> pwm_output_pin[1] == ~$past(out_cfg.active_level_bit[1]))
    else $error("match in tick cycle did not set output");

  // Buffers change only at load points
  a_buffer_holds: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && !load_now |=> $stable(q.buf_cmp))
    else $error("compare buffer changed outside a load point");

  // Interrupt-routed pin raises stop-release interrupt
  a_route_irq: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && pin_rise[1] && !irq21_route_select |=>
    stop_release_irq[1])
    else $error("routed pin did not raise stop-release interrupt");

  // Timer-routed pin A forces a stop, no interrupt
  a_route_timer: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && pin_rise[0] && irq20_route_select |=>
    !stop_release_irq[0] && (q.follow == 2'b00))
    else $error("timer-routed pin acted as interrupt");

  // Pins move only on ticks or forced stop
  a_pin_holds: assert property (
    @(posedge core_clk) disable iff (rst)
    s_quiet_cycle |=> $stable(pwm_output_pin))
    else $error("output pin changed between ticks");

  // Interrupt only follows a tick
  a_irq_on_tick: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && !count_tick |=> !timer_period_interrupt)
    else $error("interrupt raised without a tick");

  // A tick always consumes a pending trigger
  a_trig_consumed: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && count_tick |=> !q.trig_pend)
    else $error("pending trigger survived a tick");

  // Stopped counter without a start request stays stopped
  a_no_start_alone: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && !q.run && !q.start_pend |=> !q.run)
    else $error("counter ran without a start request");

  // Pin drive is the inverse of direction bits 1:0 one cycle later
  a_drive_follows: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en |=> pwm_pin_drive == ~$past(q.pm[1:0]))
    else $error("pin drive does not follow direction bits");

  // Direction write lands at the next edge
  a_dir_write: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && port20_wr |=> port20_direction == $past(port20_wdata))
    else $error("direction write did not land");

  // Stop-release interrupt only from an interrupt-routed edge
  a_ext_irq_source: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && !(pin_rise[0] && !irq20_route_select) |=>
    !stop_release_irq[0])
    else $error("stop-release interrupt without routed edge");

  // Forced stop drives default levels next cycle
  a_force_default: assert property (
    @(posedge core_clk) disable iff (rst)
    s_force_cycle |=> pwm_output_pin == $past(q.tod))
    else $error("forced stop did not drive default levels");

endmodule // pwm_timer_counter_output_core

// [trig_pin_model.sv]
`timescale 1ns/10ps
module trig_pin_model (
  input wire logic core_clk,
  input wire logic fire_a,
  input wire logic fire_b,
  output logic ext_irq_pin_a,
  output logic ext_irq_pin_b
);
  logic [3:0] hold_a_q;
  logic [3:0] hold_b_q;

  // Start with both trigger lines quiet
  initial begin
    hold_a_q = 4'h0;
    hold_b_q = 4'h0;
  end

  // Stretch a fire request so the pin synchroniser can see it
  always @(posedge core_clk) begin
    hold_a_q <= fire_a ? 4'h8 : (hold_a_q != 4'h0 ? hold_a_q - 4'h1 : 4'h0);
    hold_b_q <= fire_b ? 4'h8 : (hold_b_q != 4'h0 ? hold_b_q - 4'h1 : 4'h0);
  end

  // Lines are pulled low between events
  assign ext_irq_pin_a = (hold_a_q != 4'h0);
  assign ext_irq_pin_b = (hold_b_q != 4'h0);
endmodule // trig_pin_model

// [tb_pwm_timer_counter_output_core.sv]
`timescale 1ns/10ps
module tb_pwm_timer_counter_output_core;
  logic core_clk, rst, count_tick, counter_enable_bit, period_by_trigger;
  logic irq20_route_select, irq21_route_select, port20_wr, fire_a, fire_b;
  logic ext_irq_pin_a, ext_irq_pin_b, timer_period_interrupt;
  logic [7:0] port20_wdata, port20_direction;
  pwm_core_pkg::cmp_cfg_t cmp_cfg;
  pwm_core_pkg::out_cfg_t out_cfg;
  logic [15:0] timer_up_counter;
  logic [1:0] pwm_output_pin, pwm_pin_drive, stop_release_irq, tdiv;
  int fails, comparisons, cycles, k, n;

  // Clock of 25 ns
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Count tick every fourth cycle
  initial tdiv = 2'h0;
  always @(negedge core_clk) begin
    tdiv <= tdiv + 2'h1;
    count_tick <= (tdiv == 2'h3);
  end

  // Cut a hang short
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      print_verdict();
    end
  end

  pwm_timer_counter_output_core i_pwm_timer_counter_output_core (
    .core_clk(core_clk), .rst(rst), .clk_en(1'b1), .count_tick(count_tick),
    .counter_enable_bit(counter_enable_bit),
    .period_by_trigger(period_by_trigger), .trig_load_en(1'b0),
    .batch_load_req(1'b0), .cmp_cfg(cmp_cfg), .out_cfg(out_cfg),
    .irq20_route_select(irq20_route_select),
    .irq21_route_select(irq21_route_select),
    .ext_irq_pin_a(ext_irq_pin_a), .ext_irq_pin_b(ext_irq_pin_b),
    .port20_wr(port20_wr), .port20_wdata(port20_wdata),
    .timer_up_counter(timer_up_counter),
    .timer_period_interrupt(timer_period_interrupt),
    .pwm_output_pin(pwm_output_pin), .pwm_pin_drive(pwm_pin_drive),
    .stop_release_irq(stop_release_irq), .port20_direction(port20_direction)
  );

  trig_pin_model i_trig_pin_model (
    .core_clk(core_clk), .fire_a(fire_a), .fire_b(fire_b),
    .ext_irq_pin_a(ext_irq_pin_a), .ext_irq_pin_b(ext_irq_pin_b)
  );

  // Compare and count
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Pass one count tick and let it settle
  task automatic wait_tick();
    @(posedge core_clk iff count_tick === 1'b1);
    @(negedge core_clk);
  endtask

  // Run ticks until the counter shows a value
  task automatic wait_cnt(input logic [15:0] v);
    n = 0;
    do begin
      wait_tick();
      n++;
    end while (timer_up_counter !== v && n < 40);
  endtask

  // Wait for the period interrupt
  task automatic wait_irq();
    k = 0;
    while (timer_period_interrupt !== 1'b1 && k < 12) begin
      @(negedge core_clk);
      k++;
    end
  endtask

  task automatic print_verdict();
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    counter_enable_bit = 1'b0;
    period_by_trigger = 1'b0;
    irq20_route_select = 1'b0;
    irq21_route_select = 1'b0;
    port20_wr = 1'b0;
    port20_wdata = 8'h00;
    fire_a = 1'b0;
    fire_b = 1'b0;
    cmp_cfg = '0;
    cmp_cfg.period = 16'h0009;
    cmp_cfg.set_cmp[0] = 16'h0002;
    cmp_cfg.reset_cmp[0] = 16'h0006;
    cmp_cfg.set_cmp[1] = 16'h0003;
    cmp_cfg.reset_cmp[1] = 16'h0005;
    out_cfg.output_enable_bit = 2'h3;
    out_cfg.default_level_bit = 2'h2;
    out_cfg.active_level_bit = 2'h2;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    check("counter", timer_up_counter, pwm_core_pkg::CNT_INIT);
    check("dir", {8'h00, port20_direction}, 16'h00FF);
    port20_wr = 1'b1;
    port20_wdata = 8'hFC;
    @(negedge core_clk);
    port20_wr = 1'b0;
    @(negedge core_clk);
    check("dir", {8'h00, port20_direction}, 16'h00FC);
    check("drive", {14'h0000, pwm_pin_drive}, 16'h0003);
    counter_enable_bit = 1'b1;
    wait_irq();
    check("start", 16'(k > 0 && k <= 6), 16'h0001);
    check("counter", timer_up_counter, 16'h0000);
    cmp_cfg.period = 16'h000C;
    for (int i = 1; i <= 20; i++) begin
      wait_tick();
      check("counter", timer_up_counter, 16'(i % 10));
      check("irq", 16'(timer_period_interrupt), 16'(i % 10 == 0));
      check("pin0", 16'(pwm_output_pin[0]), 16'(i % 10 inside {[2:5]}));
      check("pin1", 16'(pwm_output_pin[1]), 16'(!(i % 10 inside {3, 4})));
    end
    cmp_cfg.period = 16'h0009;
    wait_cnt(16'h0003);
    out_cfg.output_enable_bit[0] = 1'b0;
    wait_tick();
    check("pin0", 16'(pwm_output_pin[0]), 16'h0000);
    out_cfg.default_level_bit[0] = 1'b1;
    wait_tick();
    check("pin0", 16'(pwm_output_pin[0]), 16'h0001);
    out_cfg.default_level_bit[0] = 1'b0;
    wait_cnt(16'h0003);
    out_cfg.output_enable_bit[0] = 1'b1;
    wait_tick();
    check("pin0", 16'(pwm_output_pin[0]), 16'h0000);
    wait_cnt(16'h0002);
    check("pin0", 16'(pwm_output_pin[0]), 16'h0001);
    counter_enable_bit = 1'b0;
    wait_tick();
    check("counter", timer_up_counter, 16'hFFFF);
    check("pins", {14'h0000, pwm_output_pin}, 16'h0002);
    repeat (3) wait_tick();
    check("counter", timer_up_counter, 16'hFFFF);
    period_by_trigger = 1'b1;
    irq21_route_select = 1'b1;
    counter_enable_bit = 1'b1;
    wait_irq();
    wait_cnt(16'h0003);
    fire_b = 1'b1;
    @(negedge core_clk);
    fire_b = 1'b0;
    k = 0;
    while (timer_up_counter !== 16'h0000 && k < 16) begin
      @(negedge core_clk);
      k++;
    end
    check("counter", timer_up_counter, 16'h0000);
    check("irq", 16'(timer_period_interrupt), 16'h0000);
    check("wake_b", 16'(stop_release_irq[1]), 16'h0000);
    fire_a = 1'b1;
    @(negedge core_clk);
    fire_a = 1'b0;
    k = 0;
    while (stop_release_irq[0] !== 1'b1 && k < 12) begin
      @(negedge core_clk);
      k++;
    end
    check("wake_a", 16'(stop_release_irq[0]), 16'h0001);
    repeat (12) @(negedge core_clk);
    irq20_route_select = 1'b1;
    fire_a = 1'b1;
    @(negedge core_clk);
    fire_a = 1'b0;
    n = 0;
    repeat (10) begin
      @(negedge core_clk);
      n = n | stop_release_irq[0];
    end
    check("wake_a_off", 16'(n), 16'h0000);
    print_verdict();
  end
endmodule // tb_pwm_timer_counter_output_core
